// File: acsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module acsr_host (
  input wire logic clk_sys,
  input wire logic data_line,
  input wire logic data_oe_n,
  input wire logic clk_line,
  output logic cs_n,
  output logic sclk
);
  int hi_len;
  int lo_len;
  logic rx_bit;

  // Released data line floats to the inverse of its last value
  assign rx_bit = data_oe_n ? ~data_line : data_line;

  // Deselected and clock low until asked
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    hi_len = 0;
  end

  // Host-timed read, MSB first, sampled before each rising edge
  task automatic read_host(input int nbits, output logic [19:0] w, output logic ok);
    w = '0;
    ok = 1'b1;
    @(posedge clk_sys);
    cs_n <= 1'h0;
    repeat (44) @(posedge clk_sys); // Four master periods plus 300 ns
    for (int i = 0; i < nbits; i++) begin
      ok &= (data_oe_n === 1'b0);
      w = {w[18:0], rx_bit};
      sclk <= 1'h1;
      repeat (8) @(posedge clk_sys);
      sclk <= 1'h0;
      repeat (8) @(posedge clk_sys);
    end
  endtask

  // Self-timed read, sampled while the device clock is high
  task automatic read_self(output logic [19:0] w, output logic ok);
    int g;
    w = '0;
    ok = 1'b1;
    @(posedge clk_sys);
    cs_n <= 1'h0;
    for (int i = 0; i < 20; i++) begin
      g = 0;
      while (clk_line !== 1'b1 && g < 200) begin
        @(negedge clk_sys);
        g++;
      end
      if (i == 1) lo_len = g;
      ok &= (data_oe_n === 1'b0) && (g < 200);
      w = {w[18:0], rx_bit};
      g = 0;
      while (clk_line === 1'b1 && g < 200) begin
        @(negedge clk_sys);
        g++;
      end
      if (i == 0) hi_len = g;
    end
    @(posedge clk_sys);
    cs_n <= 1'h1;
  endtask

  task automatic select_dev();
    @(posedge clk_sys);
    cs_n <= 1'h0;
  endtask

  task automatic deselect();
    @(posedge clk_sys);
    cs_n <= 1'h1;
  endtask

  // One full clock pulse, ending on a falling edge
  task automatic pulse();
    @(posedge clk_sys);
    sclk <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sclk <= 1'h0;
  endtask
endmodule
`default_nettype wire

// File: acsr_pkg.sv
package acsr_pkg;

  // Word and timing counts
  localparam int WORD_BITS = 20;
  localparam int READY_HIGH_TICKS = 4;
  localparam int CAL_HOLD_MCLK = 4;
  localparam int SCLK_DIV = 4;

  // Reset values
  localparam logic WORD_READY_N_RST = 1'h1;
  localparam logic DEVICE_RESET_RST = 1'h0;

  // Serial port sequencing
  typedef enum logic [1:0] {
    ACSR_IDLE = 2'b00,
    ACSR_UPDATE = 2'b01,
    ACSR_ARMED = 2'b10,
    ACSR_SHIFT = 2'b11
  } acsr_state_e;

  // Pins arriving from outside the clk_sys domain
  typedef struct packed {
    logic master_clock_in;
    logic cs_n;
    logic sclk_in;
    logic cal;
    logic trim_select_a;
    logic trim_select_b;
    logic serial_mode;
    logic signed_range_select;
  } acsr_pins_s;

  // Calibration choice latched at the strobe's rising edge
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic system_cal;
  } acsr_cal_s;

endpackage

// File: acsr_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module acsr_shifter #(
  parameter int WORD_BITS = acsr_pkg::WORD_BITS,
  parameter int SCLK_DIV = acsr_pkg::SCLK_DIV
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [WORD_BITS-1:0] word,
  input wire logic self_timed,
  input wire logic mclk_tick,
  input wire logic sclk_fall,
  input wire logic stop_req,
  output logic busy,
  output logic done,
  output logic sd_bit,
  output logic sclk_out
);
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam int PW = $clog2(SCLK_DIV);

  logic [WORD_BITS-1:0] shift_reg;
  logic [CW-1:0] bits_reg;
  logic [PW-1:0] phase_reg;
  logic stop_reg;
  logic bit_end;
  logic finish;

  // End of a bit: host falling edge, or own clock falling edge
  assign bit_end = busy && (self_timed ? (mclk_tick && phase_reg == PW'(0)) : sclk_fall);
  // Last bit, or chip select gone: current bit is complete
  assign finish = bit_end && (bits_reg == CW'(WORD_BITS - 1) || stop_reg || stop_req);

  // Transfer in progress
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'h0;
    end else if (start) begin
      busy <= 1'h1;
    end else if (finish) begin
      busy <= 1'h0;
    end
  end

  // Shift register, MSB first, next bit on each falling edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_reg <= '0;
      sd_bit <= 1'h0;
    end else if (start) begin
      shift_reg <= word;
      sd_bit <= word[WORD_BITS-1];
    end else if (bit_end && !finish) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], 1'h0};
      sd_bit <= shift_reg[WORD_BITS-2];
    end
  end

  // Completed bit count
  always_ff @(posedge clk_sys) begin
    if (rst || start) begin
      bits_reg <= '0;
    end else if (bit_end) begin
      bits_reg <= bits_reg + CW'(1);
    end
  end

  // Early chip select release remembered until the bit ends
  always_ff @(posedge clk_sys) begin
    if (rst || start) begin
      stop_reg <= 1'h0;
    end else if (busy && stop_req) begin
      stop_reg <= 1'h1;
    end
  end

  // Own serial clock: one phase high out of four master ticks
  always_ff @(posedge clk_sys) begin
    if (rst || start) begin
      phase_reg <= PW'(1);
      sclk_out <= 1'h0;
    end else if (!busy) begin
      sclk_out <= 1'h0;
    end else if (self_timed && mclk_tick) begin
      phase_reg <= phase_reg + PW'(1);
      sclk_out <= (phase_reg == PW'(SCLK_DIV - 1));
    end
  end

  // Pulse when the pins are released
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done <= 1'h0;
    end else begin
      done <= finish;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_HOLD_BETWEEN_EDGES: assert property ((busy && !bit_end) |=> $stable(sd_bit))
    else $error("serial data moved without a falling edge");
  AST_FINISH_CURRENT_BIT: assert property ((busy && stop_reg && !bit_end) |=> busy)
    else $error("released before the current bit ended");
  AST_RELEASE_AFTER_BIT: assert property ((bit_end && stop_reg) |=> !busy ##1 !busy)
    else $error("still driving after stop at bit end");
  AST_SCLK_FALL_PHASE: assert property ($fell(sclk_out) && busy |-> phase_reg == PW'(1))
    else $error("own serial clock high for more than one phase");
  AST_SCLK_RISE_PHASE: assert property ($rose(sclk_out) |-> phase_reg == PW'(0))
    else $error("own serial clock rose in the wrong phase");
endmodule
`default_nettype wire

// File: acsr_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Chip select released mid-word: finish current bit, then float data and clock.
// - Chip select falling while word-ready is high for four ticks is ignored.
// - Host-timed mode: next data bit appears on each host clock falling edge.
// - Second select low at calibration means system calibration against the input pin.
// - Bipolar words use offset binary, midscale step at analog ground.
// - Mode pin low: host clocks, MSB first; high: device makes the clock.
// - Own serial clock is master clock over four, high one quarter.
// - Strobe high over four master ticks resets; calibration starts when it falls.
// - Both select inputs latched at strobe rising edge choose calibration type.
module acsr_top #(
  parameter int WORD_BITS = acsr_pkg::WORD_BITS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire acsr_pkg::acsr_pins_s pins_in,
  input wire logic [WORD_BITS-1:0] conv_word,
  input wire logic conv_valid,
  output logic serial_out_line,
  output logic serial_out_oe_n,
  output logic serial_clock_out,
  output logic serial_clock_oe_n,
  output logic word_ready_n,
  output logic device_reset,
  output logic cal_start,
  output acsr_pkg::acsr_cal_s cal_cfg
);
  localparam int NP = $bits(acsr_pkg::acsr_pins_s);

  logic [NP-1:0] sync1_reg;
  logic [NP-1:0] sync2_reg;
  logic [NP-1:0] prev_reg;
  logic [NP-1:0] rise;
  logic [NP-1:0] fall;
  acsr_pkg::acsr_pins_s pin_s;
  acsr_pkg::acsr_pins_s pin_rise;
  acsr_pkg::acsr_pins_s pin_fall;
  acsr_pkg::acsr_state_e state_reg;
  logic [2:0] upd_cnt_reg;
  logic [2:0] cal_cnt_reg;
  logic [WORD_BITS-1:0] word_reg;
  logic cs_ignore_reg;
  logic mclk_tick;
  logic self_timed;
  logic serial_rst;
  logic start;
  logic busy;
  logic done;
  logic sd_bit;
  logic sclk;

  // Two-stage synchronisers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      // Free-running: fills with pin levels during reset, so no false edge after it
      always_ff @(posedge clk_sys) begin
        sync1_reg[gi] <= pins_in[gi];
        sync2_reg[gi] <= sync1_reg[gi];
        prev_reg[gi] <= sync2_reg[gi];
      end
    end
  endgenerate

  // Synchronised levels and their edges
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign pin_s = acsr_pkg::acsr_pins_s'(sync2_reg);
  assign pin_rise = acsr_pkg::acsr_pins_s'(rise);
  assign pin_fall = acsr_pkg::acsr_pins_s'(fall);
  assign mclk_tick = pin_rise.master_clock_in;
  assign self_timed = pin_s.serial_mode;
  assign serial_rst = rst || device_reset;
  assign start = (state_reg == acsr_pkg::ACSR_ARMED) && !pin_s.cs_n && !cs_ignore_reg;

  // Calibration strobe hold counter in master ticks
  always_ff @(posedge clk_sys) begin
    if (rst || !pin_s.cal) begin
      cal_cnt_reg <= 3'h0;
    end else if (mclk_tick && cal_cnt_reg <= 3'(acsr_pkg::CAL_HOLD_MCLK)) begin
      cal_cnt_reg <= cal_cnt_reg + 3'h1;
    end
  end

  // Reset while held long; calibration begins on release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      device_reset <= acsr_pkg::DEVICE_RESET_RST;
      cal_start <= 1'h0;
    end else begin
      device_reset <= pin_s.cal && (cal_cnt_reg > 3'(acsr_pkg::CAL_HOLD_MCLK));
      cal_start <= pin_fall.cal && device_reset;
    end
  end

  // Calibration choice caught at the strobe's rising edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_cfg <= '0;
    end else if (pin_rise.cal) begin
      cal_cfg.sel_a <= pin_s.trim_select_a;
      cal_cfg.sel_b <= pin_s.trim_select_b;
      cal_cfg.system_cal <= !pin_s.trim_select_b;
    end
  end

  // Serial port sequencing
  always_ff @(posedge clk_sys) begin
    if (serial_rst) begin
      state_reg <= acsr_pkg::ACSR_IDLE;
      word_ready_n <= acsr_pkg::WORD_READY_N_RST;
      upd_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        acsr_pkg::ACSR_IDLE, acsr_pkg::ACSR_ARMED: begin
          if (conv_valid && !start) begin
            state_reg <= acsr_pkg::ACSR_UPDATE;
            word_ready_n <= 1'h1;
            upd_cnt_reg <= 3'h0;
          end else if (start) begin
            state_reg <= acsr_pkg::ACSR_SHIFT;
          end
        end
        acsr_pkg::ACSR_UPDATE: begin
          if (mclk_tick) begin
            if (upd_cnt_reg == 3'(acsr_pkg::READY_HIGH_TICKS - 1)) begin
              state_reg <= acsr_pkg::ACSR_ARMED;
              word_ready_n <= 1'h0;
            end else begin
              upd_cnt_reg <= upd_cnt_reg + 3'h1;
            end
          end
        end
        acsr_pkg::ACSR_SHIFT: begin
          if (done) begin
            state_reg <= acsr_pkg::ACSR_IDLE;
            word_ready_n <= 1'h1;
          end
        end
        default: begin
          state_reg <= acsr_pkg::ACSR_IDLE;
        end
      endcase
    end
  end

  // Word capture, offset binary in bipolar range
  always_ff @(posedge clk_sys) begin
    if (serial_rst) begin
      word_reg <= '0;
    end else if (conv_valid && !start && state_reg != acsr_pkg::ACSR_SHIFT
                 && state_reg != acsr_pkg::ACSR_UPDATE) begin
      word_reg <= conv_word;
      word_reg[WORD_BITS-1] <= conv_word[WORD_BITS-1] ^ pin_s.signed_range_select;
    end
  end

  // Select asserted during the update window is not honoured
  always_ff @(posedge clk_sys) begin
    if (serial_rst || pin_s.cs_n) begin
      cs_ignore_reg <= 1'h0;
    end else if (pin_fall.cs_n && state_reg == acsr_pkg::ACSR_UPDATE) begin
      cs_ignore_reg <= 1'h1;
    end
  end

  acsr_shifter #(
    .WORD_BITS(WORD_BITS),
    .SCLK_DIV(acsr_pkg::SCLK_DIV)
  ) u_shifter (
    .clk_sys(clk_sys),
    .rst(serial_rst),
    .start(start),
    .word(word_reg),
    .self_timed(self_timed),
    .mclk_tick(mclk_tick),
    .sclk_fall(pin_fall.sclk_in),
    .stop_req(pin_s.cs_n),
    .busy(busy),
    .done(done),
    .sd_bit(sd_bit),
    .sclk_out(sclk)
  );

  // Pin drive: float whenever no transfer is under way
  assign serial_out_line = sd_bit;
  assign serial_clock_out = sclk;
  assign serial_out_oe_n = !busy;
  assign serial_clock_oe_n = !(busy && self_timed);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_FLOAT_WHEN_IDLE: assert property (!busy |-> serial_out_oe_n && serial_clock_oe_n)
    else $error("pins driven with no transfer");
  AST_HOST_CLOCK_INPUT: assert property (!self_timed |-> serial_clock_oe_n)
    else $error("clock driven in host-timed mode");
  AST_IGNORE_CS_WINDOW: assert property (
    (state_reg == acsr_pkg::ACSR_UPDATE && pin_fall.cs_n) |=> !start)
    else $error("select honoured inside update window");
  AST_READY_HIGH_UPDATE: assert property (
    (state_reg == acsr_pkg::ACSR_UPDATE) |-> word_ready_n)
    else $error("word ready low while updating");
  AST_READY_FALL_CAUSE: assert property (
    $fell(word_ready_n) |-> $past(state_reg) == acsr_pkg::ACSR_UPDATE && $past(mclk_tick))
    else $error("word ready fell without update end");
  AST_OFFSET_BINARY: assert property (
    (conv_valid && state_reg == acsr_pkg::ACSR_IDLE && !device_reset
    && pin_s.signed_range_select) |=> word_reg
    == {~$past(conv_word[WORD_BITS-1]), $past(conv_word[WORD_BITS-2:0])})
    else $error("bipolar word MSB not inverted");
  AST_CAL_RESET: assert property (
    (pin_s.cal && cal_cnt_reg > 3'(acsr_pkg::CAL_HOLD_MCLK)) |=> device_reset)
    else $error("long strobe did not reset");
  AST_CAL_START: assert property (
    (pin_fall.cal && device_reset) |=> cal_start ##1 !cal_start)
    else $error("calibration did not start on strobe release");
  AST_CAL_LATCH: assert property (
    pin_rise.cal |=> cal_cfg.sel_b == $past(pin_s.trim_select_b)
    && cal_cfg.sel_a == $past(pin_s.trim_select_a)
    && cal_cfg.system_cal == !$past(pin_s.trim_select_b))
    else $error("calibration selects not latched");

  COV_HOST_WORD: cover property (!self_timed && state_reg == acsr_pkg::ACSR_SHIFT && done);
  COV_SELF_WORD: cover property (self_timed && state_reg == acsr_pkg::ACSR_SHIFT && done);
  COV_CAL_START: cover property (cal_start);
  COV_CS_IGNORED: cover property (cs_ignore_reg);
endmodule
`default_nettype wire

// File: adc_serial_readout_cal_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_cal_tb;
  typedef struct packed {
    logic self_m;
    logic bip;
    logic [19:0] w;
    logic [19:0] exp;
  } acsr_row_s;
  logic clk_sys, rst, conv_valid, mclk, cal, sel_a, sel_b, mode, bip, ok;
  logic [19:0] conv_word, got;
  logic cs_n, sclk, sd_line, sd_oe_n, sck, sck_oe_n, wr_n, dev_rst, cal_go;
  acsr_pkg::acsr_cal_s cfg;
  acsr_pkg::acsr_pins_s pins;
  int mismatches, cmp_count, cycles, g;
  acsr_row_s rows [6] = '{
    '{1'h0, 1'h0, 20'hA5C3F, 20'hA5C3F}, '{1'h0, 1'h1, 20'h7FFFF, 20'hFFFFF},
    '{1'h0, 1'h1, 20'h00000, 20'h80000}, '{1'h1, 1'h0, 20'h12345, 20'h12345},
    '{1'h1, 1'h1, 20'h80000, 20'h00000}, '{1'h1, 1'h1, 20'hFFFFF, 20'h7FFFF}};

  assign pins = {mclk, cs_n, sclk, cal, sel_a, sel_b, mode, bip};

  acsr_top dut_u (.clk_sys(clk_sys), .rst(rst), .pins_in(pins), .conv_word(conv_word),
    .conv_valid(conv_valid), .serial_out_line(sd_line), .serial_out_oe_n(sd_oe_n),
    .serial_clock_out(sck), .serial_clock_oe_n(sck_oe_n), .word_ready_n(wr_n),
    .device_reset(dev_rst), .cal_start(cal_go), .cal_cfg(cfg));

  acsr_host host_u (.clk_sys(clk_sys), .data_line(sd_line), .data_oe_n(sd_oe_n),
    .clk_line(sck), .cs_n(cs_n), .sclk(sclk));

  // System clock, and a master clock that never stops
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    mclk = 1'h0;
    #7;
    forever #100 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input logic [19:0] act, input logic [19:0] exp);
    cmp_count++;
    if (act !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic put_word(input logic [19:0] w);
    @(posedge clk_sys);
    conv_word <= w;
    conv_valid <= 1'h1;
    @(posedge clk_sys);
    conv_valid <= 1'h0;
  endtask

  task automatic wait_ready();
    g = 0;
    while (wr_n !== 1'b0 && g < 80) begin
      @(negedge clk_sys);
      g++;
    end
    check(20'(g >= 20 && g < 50), 20'h1);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {rst, conv_valid, cal, sel_a, sel_b, mode, bip} = 7'h40;
    conv_word = '0;
    {mismatches, cmp_count, cycles} = '0;
    repeat (20) @(negedge clk_sys);
    check({14'h0, sd_oe_n, sck_oe_n, wr_n, dev_rst, cal_go, cfg[0]}, 20'h38);
    @(posedge clk_sys);
    rst <= 1'h0;
    // Ordinary transfers in both modes and both ranges
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      mode <= rows[i].self_m;
      bip <= rows[i].bip;
      repeat (4) @(posedge clk_sys);
      put_word(rows[i].w);
      wait_ready();
      if (rows[i].self_m) host_u.read_self(got, ok);
      else host_u.read_host(20, got, ok);
      check(got, rows[i].exp);
      check({19'h0, ok}, 20'h1);
      if (rows[i].self_m) check(20'(host_u.hi_len), 20'h8);
      if (rows[i].self_m) check(20'(host_u.lo_len), 20'h18);
      host_u.deselect();
      repeat (6) @(negedge clk_sys);
      check({17'h0, wr_n, sd_oe_n, sck_oe_n}, 20'h7);
    end
    // Early deselect finishes the bit in progress
    @(posedge clk_sys);
    {mode, bip} <= 2'h0;
    repeat (4) @(posedge clk_sys); // Range pin settled before the word
    put_word(20'hF0F0F);
    wait_ready();
    host_u.read_host(5, got, ok);
    check(got, 20'h0001E);
    host_u.deselect();
    repeat (12) @(negedge clk_sys);
    check({19'h0, sd_oe_n}, 20'h0);
    host_u.pulse();
    repeat (8) @(negedge clk_sys);
    check({18'h0, sd_oe_n, wr_n}, 20'h3);
    // Select during the update interval is ignored
    put_word(20'h3C3C3);
    host_u.select_dev();
    wait_ready();
    repeat (30) @(negedge clk_sys);
    check({19'h0, sd_oe_n}, 20'h1);
    host_u.deselect();
    repeat (8) @(posedge clk_sys);
    host_u.read_host(20, got, ok);
    check(got, 20'h3C3C3);
    host_u.deselect();
    // Long strobe for every select pair: reset, then calibration start
    for (int k = 0; k < 4; k++) begin // Zero-scale system step before full-scale step
      @(posedge clk_sys);
      {sel_a, sel_b} <= 2'(k);
      repeat (4) @(posedge clk_sys);
      cal <= 1'h1;
      repeat (60) @(posedge clk_sys);
      sel_a <= ~sel_a; // Held past the edge, then changed
      repeat (4) @(negedge clk_sys);
      check({17'h0, cfg}, {17'h0, 2'(k), ~k[0]});
      check({19'h0, dev_rst}, 20'h1);
      @(posedge clk_sys);
      cal <= 1'h0;
      g = 0;
      while (cal_go !== 1'b1 && g < 20) begin
        @(negedge clk_sys);
        g++;
      end
      check({18'h0, 1'(g < 20), dev_rst}, 20'h2);
    end
    // Short strobe latches selects but does not reset
    @(posedge clk_sys);
    sel_b <= 1'h1;
    repeat (4) @(posedge clk_sys);
    cal <= 1'h1; // Selects settled before the strobe
    repeat (16) @(posedge clk_sys);
    cal <= 1'h0;
    g = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (cal_go !== 1'b0 || dev_rst !== 1'b0) g++;
    end
    check(20'(g), 20'h0);
    check({17'h0, cfg}, 20'h2);
    results();
  end
endmodule
`default_nettype wire
